// ### rtl/fpc_top.sv
// protection decode, function register and read parameter pair behind a serial port
`include "fpc_cfg.svh"
`default_nettype none
module fpc_top #(
  parameter int NUM_BLOCKS = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic write_enable_latch,
  input wire logic quad_enable,
  input wire logic four_lane_command_mode,
  input wire logic program_busy,
  input wire logic erase_busy,
  input wire logic protect_code_bit3,
  input wire logic protect_code_bit2,
  input wire logic protect_code_bit1,
  input wire logic protect_code_bit0,
  input wire logic op_req,
  input wire logic op_is_info_row,
  input wire logic [$clog2(NUM_BLOCKS)-1:0] target_block,
  input wire logic [1:0] target_row,
  output logic op_inhibit,
  output logic [NUM_BLOCKS-1:0] protect_mask,
  output logic [7:0] suspend_and_row_lock,
  output logic [7:0] read_parameters,
  output logic [7:0] read_parameters_persistent,
  output logic pin_is_reset,
  output logic pin_is_data_lane3,
  output logic [3:0] dummy_count,
  output logic dummy_use_default,
  output logic wrap_enable,
  output logic [6:0] burst_bytes
);
  import fpc_pkg::*;

  localparam int HALF = NUM_BLOCKS / 2;

  // pins come from the host clock domain
  logic sck_s1_r, sck_s2_r, sck_s3_r, cs_s1_r, cs_s2_r, mosi_s1_r, mosi_s2_r;
  fpc_state_t state_r, state_nxt;
  logic [2:0] bit_cnt_r;
  logic [7:0] rx_r, opc_r, tx_r;
  logic tx_armed_r, rd_cmd_r;
  logic [7:0] nv_r, vol_r;
  logic powerup_load_r;
  logic program_suspended_flag_r, erase_suspended_flag_r;
  logic [3:0] lock_r;
  logic miso_r, miso_oe_r, inhibit_r;
  logic [NUM_BLOCKS-1:0] mask_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_s3_r <= 1'b0;
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      mosi_s1_r <= 1'b0;
      mosi_s2_r <= 1'b0;
    end else begin
      sck_s1_r <= sck;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      cs_s1_r <= cs_n;
      cs_s2_r <= cs_s1_r;
      mosi_s1_r <= mosi;
      mosi_s2_r <= mosi_s1_r;
    end
  end

  // edges found only on the second and third stages
  wire sck_rise = sck_s2_r & ~sck_s3_r;
  wire sck_fall = ~sck_s2_r & sck_s3_r;
  wire selected = ~cs_s2_r;
  wire byte_done = selected & sck_rise & (bit_cnt_r == 3'h7);
  wire [7:0] byte_in = {rx_r[6:0], mosi_s2_r};
  wire opc_done = byte_done & (state_r == FPC_OPCODE);
  wire pay_done = byte_done & (state_r == FPC_PAYLOAD);

  wire is_wr_nv = byte_in == `FPC_OP_SET_RP_NV;
  wire is_wr_v = (byte_in == `FPC_OP_SET_RP_V0) | (byte_in == `FPC_OP_SET_RP_V1);
  wire is_wr_fr = byte_in == `FPC_OP_WR_FUNC;
  wire is_rd_fr = byte_in == `FPC_OP_RD_FUNC;
  wire is_rd_rp = byte_in == `FPC_OP_RD_RP;
  wire is_susp = byte_in == `FPC_OP_SUSPEND;
  wire is_resume = byte_in == `FPC_OP_RESUME;
  wire has_payload = is_wr_nv | is_wr_v | is_wr_fr | is_rd_fr | is_rd_rp;

  // persistent writes depend on the host having sent write enable first
  // write enable gate
  wire nv_wr = pay_done & (opc_r == `FPC_OP_SET_RP_NV) & write_enable_latch;
  wire v_wr = pay_done & ((opc_r == `FPC_OP_SET_RP_V0) | (opc_r == `FPC_OP_SET_RP_V1));
  wire fr_wr = pay_done & (opc_r == `FPC_OP_WR_FUNC) & write_enable_latch;

  wire [7:0] fr_value = {lock_r, erase_suspended_flag_r, program_suspended_flag_r, 2'b00};
  wire [7:0] rd_value = is_rd_fr ? fr_value : vol_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FPC_IDLE: begin
        if (selected) begin
          state_nxt = FPC_OPCODE;
        end
      end
      FPC_OPCODE: begin
        if (opc_done) begin
          state_nxt = has_payload ? FPC_PAYLOAD : FPC_IGNORE;
        end
      end
      FPC_PAYLOAD: begin
        if (pay_done && !rd_cmd_r) begin
          state_nxt = FPC_IGNORE;
        end
      end
      default: state_nxt = FPC_IGNORE;
    endcase
    if (!selected) begin
      state_nxt = FPC_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= FPC_IDLE;
      bit_cnt_r <= 3'h0;
      rx_r <= 8'h00;
      opc_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (!selected) begin
        bit_cnt_r <= 3'h0;
      end else if (sck_rise) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
        rx_r <= byte_in;
      end
      if (opc_done) begin
        opc_r <= byte_in;
      end
    end
  end

  // read data: first bit shows before the first payload rise, repeats per byte
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_r <= 8'h00;
      tx_armed_r <= 1'b0;
      rd_cmd_r <= 1'b0;
    end else if (!selected) begin
      tx_armed_r <= 1'b0;
      rd_cmd_r <= 1'b0;
    end else if (opc_done) begin
      tx_r <= rd_value;
      rd_cmd_r <= is_rd_fr | is_rd_rp;
      tx_armed_r <= 1'b0;
    end else if (pay_done && rd_cmd_r) begin
      tx_r <= (opc_r == `FPC_OP_RD_FUNC) ? fr_value : vol_r;
      tx_armed_r <= 1'b0;
    end else if (state_r == FPC_PAYLOAD && sck_rise) begin
      tx_armed_r <= 1'b1;
    end else if (sck_fall && tx_armed_r) begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // read parameter pair; reset stands in for power-up
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nv_r <= `FPC_RP_RESET;
      vol_r <= `FPC_RP_RESET;
      powerup_load_r <= 1'b1;
    end else begin
      powerup_load_r <= 1'b0;
      if (nv_wr) begin
        nv_r <= byte_in;
      end
      if (powerup_load_r) begin
        vol_r <= nv_r;
      end else if (v_wr) begin
        vol_r <= byte_in;
      end
    end
  end

  // function register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      program_suspended_flag_r <= 1'(`FPC_FR_RESET >> `FPC_FR_PROG_SUSP_BIT);
      erase_suspended_flag_r <= 1'(`FPC_FR_RESET >> `FPC_FR_ERASE_SUSP_BIT);
      lock_r <= 4'(`FPC_FR_RESET >> `FPC_FR_LOCK_LSB);
    end else begin
      if (opc_done && is_susp && program_busy) begin
        program_suspended_flag_r <= 1'b1;
      end else if (opc_done && is_resume) begin
        program_suspended_flag_r <= 1'b0;
      end
      if (opc_done && is_susp && erase_busy) begin
        erase_suspended_flag_r <= 1'b1;
      end else if (opc_done && is_resume) begin
        erase_suspended_flag_r <= 1'b0;
      end
      if (fr_wr) begin
        lock_r <= lock_r | byte_in[7:`FPC_FR_LOCK_LSB];
      end
    end
  end

  // protected range decode
  wire [3:0] pcode = {protect_code_bit3, protect_code_bit2, protect_code_bit1, protect_code_bit0};
  wire none_sel = (pcode == `FPC_PC_NONE_LO) | (pcode == `FPC_PC_NONE_HI);
  wire top_sel = (pcode >= `FPC_PC_TOP_FIRST) & (pcode <= `FPC_PC_TOP_LAST);
  wire bot_sel = (pcode >= `FPC_PC_BOT_FIRST) & (pcode <= `FPC_PC_BOT_LAST);
  wire [1:0] top_sh = 2'(pcode - `FPC_PC_TOP_FIRST);
  wire [1:0] bot_sh = 2'(`FPC_PC_BOT_LAST - pcode);
  wire [4:0] n_blk = top_sel ? (5'h01 << top_sh) : (5'h01 << bot_sh);
  wire all_sel = ~none_sel & (~(top_sel | bot_sel) | (int'(n_blk) > HALF));
  wire [NUM_BLOCKS-1:0] mask_nxt;

  genvar gb;
  generate
    for (gb = 0; gb < NUM_BLOCKS; gb++) begin : g_blk
      // top ranges end at last block
      // bottom ranges start at block 0
      assign mask_nxt[gb] = all_sel | (top_sel & (gb >= NUM_BLOCKS - int'(n_blk)))
                            | (bot_sel & (gb < int'(n_blk)));
    end
  endgenerate

  wire inhibit_nxt = op_req & (op_is_info_row ? lock_r[target_row] : mask_nxt[target_block]);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mask_r <= '0;
      inhibit_r <= 1'b0;
      miso_r <= 1'b0;
      miso_oe_r <= 1'b0;
    end else begin
      mask_r <= mask_nxt;
      inhibit_r <= inhibit_nxt;
      miso_r <= tx_r[7];
      miso_oe_r <= selected & rd_cmd_r & (state_r == FPC_PAYLOAD);
    end
  end

  // decoded read parameters, registered to keep outputs on flops
  wire qmode = quad_enable | four_lane_command_mode;
  logic pin_rst_r, lane3_r, wrap_r, dflt_r;
  logic [3:0] dummy_r;
  logic [6:0] burst_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_rst_r <= 1'b0;
      lane3_r <= 1'b0;
      dummy_r <= 4'h0;
      dflt_r <= 1'b1;
      wrap_r <= 1'b0;
      burst_r <= `FPC_BURST_MIN;
    end else begin
      pin_rst_r <= ~qmode & vol_r[`FPC_RP_PIN_BIT];
      lane3_r <= qmode;
      dummy_r <= vol_r[`FPC_RP_DUMMY_MSB:`FPC_RP_DUMMY_LSB];
      dflt_r <= vol_r[`FPC_RP_DUMMY_MSB:`FPC_RP_DUMMY_LSB] == 4'h0;
      wrap_r <= vol_r[`FPC_RP_WRAP_BIT];
      burst_r <= `FPC_BURST_MIN << vol_r[`FPC_RP_BURST_MSB:0];
    end
  end

  assign suspend_and_row_lock = fr_value;
  assign read_parameters = vol_r;
  assign read_parameters_persistent = nv_r;
  assign protect_mask = mask_r;
  assign op_inhibit = inhibit_r;
  assign miso = miso_r;
  assign miso_oe = miso_oe_r;
  assign pin_is_reset = pin_rst_r;
  assign pin_is_data_lane3 = lane3_r;
  assign dummy_count = dummy_r;
  assign dummy_use_default = dflt_r;
  assign wrap_enable = wrap_r;
  assign burst_bytes = burst_r;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_powerup_copy: assert property (powerup_load_r |=> vol_r == $past(nv_r))
    else $error("volatile copy not loaded at power-up");
  a_prog_susp_set: assert property (
    opc_done && is_susp && program_busy |=> program_suspended_flag_r)
    else $error("program suspend flag not set");
  a_prog_susp_clear: assert property (
    opc_done && is_resume |=> !program_suspended_flag_r)
    else $error("program suspend flag not cleared");
  a_erase_susp_set: assert property (
    opc_done && is_susp && erase_busy |=> erase_suspended_flag_r)
    else $error("erase suspend flag not set");
  a_erase_susp_clear: assert property (
    opc_done && is_resume |=> !erase_suspended_flag_r)
    else $error("erase suspend flag not cleared");
  a_lock_sticky: assert property (##1 (lock_r & $past(lock_r)) == $past(lock_r))
    else $error("lock bit returned to zero");
  a_vol_write_only: assert property (v_wr |=> nv_r == $past(nv_r) && vol_r == $past(byte_in))
    else $error("volatile write touched wrong copy");
  a_code_none: assert property (pcode == `FPC_PC_NONE_LO |=> mask_r == '0)
    else $error("code zero protects blocks");
  a_code_middle: assert property (pcode == 4'h6 |=> &mask_r)
    else $error("middle code does not protect all");
  a_inhibit_blk: assert property (
    op_req && !op_is_info_row && mask_nxt[target_block] |=> op_inhibit)
    else $error("protected target not inhibited");
  a_pin_select: assert property (qmode |=> !pin_is_reset)
    else $error("pin select honoured in quad mode");
endmodule
`default_nettype wire

// ### rtl/fpc_cfg.svh
// constants of the flash protect and read configuration block
`ifndef FPC_CFG_SVH
`define FPC_CFG_SVH
`define FPC_OP_SET_RP_NV 8'h65
`define FPC_OP_SET_RP_V0 8'hc0
`define FPC_OP_SET_RP_V1 8'h63
`define FPC_OP_WR_FUNC 8'h42
`define FPC_OP_RD_FUNC 8'h48
`define FPC_OP_RD_RP 8'h61
`define FPC_OP_SUSPEND 8'h75
`define FPC_OP_RESUME 8'h7a
`define FPC_FR_PROG_SUSP_BIT 2
`define FPC_FR_ERASE_SUSP_BIT 3
`define FPC_FR_LOCK_LSB 4
`define FPC_FR_RESET 8'h00
`define FPC_RP_RESET 8'h00
`define FPC_RP_PIN_BIT 7
`define FPC_RP_DUMMY_MSB 6
`define FPC_RP_DUMMY_LSB 3
`define FPC_RP_WRAP_BIT 2
`define FPC_RP_BURST_MSB 1
`define FPC_PC_NONE_LO 4'h0
`define FPC_PC_NONE_HI 4'hf
`define FPC_PC_TOP_FIRST 4'h1
`define FPC_PC_TOP_LAST 4'h4
`define FPC_PC_BOT_FIRST 4'hb
`define FPC_PC_BOT_LAST 4'he
`define FPC_BURST_MIN 7'h08
`endif

// ### rtl/fpc_pkg.sv
// types of the flash protect and read configuration block
`default_nettype none
package fpc_pkg;
  typedef enum logic [1:0] {
    FPC_IDLE = 2'b00,
    FPC_OPCODE = 2'b01,
    FPC_PAYLOAD = 2'b11,
    FPC_IGNORE = 2'b10
  } fpc_state_t;
endpackage
`default_nettype wire

// ### test/fpc_host_model.sv
// host serial controller model for the configuration port
`default_nettype none
module fpc_host_model (
  input wire logic sys_clk,
  output logic sck,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  output logic write_enable_latch
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    write_enable_latch = 1'b0;
  end
  // write enable ahead of persistent writes
  task automatic set_write_enable();
    @(negedge sys_clk);
    write_enable_latch = 1'b1;
  endtask
  // opcode then payload, msb first, clock idles low between frames
  task automatic xfer(input logic [7:0] op, input logic [7:0] dat, input int nbits,
                      output logic [7:0] rd);
    logic [15:0] sh;
    sh = {op, dat};
    rd = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      mosi = sh[15-i];
      #80 sck = 1'b1;
      rd = {rd[6:0], miso};
      #80 sck = 1'b0;
    end
    // released line shows the inverse so a stale level cannot pass
    mosi = ~mosi;
    cs_n = 1'b1;
    #100;
    @(negedge sys_clk);
    write_enable_latch = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### test/fpc_top_tb_top.sv
// self-checking bench of the protect and read configuration block
`include "fpc_cfg.svh"
`default_nettype none
module fpc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst, sck, cs_n, mosi, miso, miso_oe, wel, quad_en, four_lane, pbusy, ebusy;
  logic op_req, op_info, op_inhibit, pin_rst, pin_l3, ddef, wrap, inh8, inh4;
  logic [3:0] pc, tblk, dcnt, pm4;
  logic [1:0] trow;
  logic [15:0] pmask, exp;
  logic [7:0] fr, rp, rpp, d, rd, vd, pm8;
  logic [6:0] burst;
  int error_cnt, samples_checked, seed, oe_cycles, oe_mark;
  fpc_top #(.NUM_BLOCKS(16)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .write_enable_latch(wel), .quad_enable(quad_en),
    .four_lane_command_mode(four_lane), .program_busy(pbusy), .erase_busy(ebusy),
    .protect_code_bit3(pc[3]), .protect_code_bit2(pc[2]), .protect_code_bit1(pc[1]),
    .protect_code_bit0(pc[0]), .op_req(op_req), .op_is_info_row(op_info),
    .target_block(tblk), .target_row(trow), .op_inhibit(op_inhibit), .protect_mask(pmask),
    .suspend_and_row_lock(fr), .read_parameters(rp), .read_parameters_persistent(rpp),
    .pin_is_reset(pin_rst), .pin_is_data_lane3(pin_l3), .dummy_count(dcnt),
    .dummy_use_default(ddef), .wrap_enable(wrap), .burst_bytes(burst));
  fpc_host_model host_u (.sys_clk(sys_clk), .sck(sck), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .write_enable_latch(wel));
  // smaller densities share the serial port and the protect code
  fpc_top #(.NUM_BLOCKS(8)) dut_m4_u (
    .sys_clk(sys_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(),
    .miso_oe(), .write_enable_latch(wel), .quad_enable(quad_en),
    .four_lane_command_mode(four_lane), .program_busy(pbusy), .erase_busy(ebusy),
    .protect_code_bit3(pc[3]), .protect_code_bit2(pc[2]), .protect_code_bit1(pc[1]),
    .protect_code_bit0(pc[0]), .op_req(op_req), .op_is_info_row(op_info),
    .target_block(tblk[2:0]), .target_row(trow), .op_inhibit(inh8), .protect_mask(pm8),
    .suspend_and_row_lock(), .read_parameters(), .read_parameters_persistent(),
    .pin_is_reset(), .pin_is_data_lane3(), .dummy_count(),
    .dummy_use_default(), .wrap_enable(), .burst_bytes());
  fpc_top #(.NUM_BLOCKS(4)) dut_m2_u (
    .sys_clk(sys_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(),
    .miso_oe(), .write_enable_latch(wel), .quad_enable(quad_en),
    .four_lane_command_mode(four_lane), .program_busy(pbusy), .erase_busy(ebusy),
    .protect_code_bit3(pc[3]), .protect_code_bit2(pc[2]), .protect_code_bit1(pc[1]),
    .protect_code_bit0(pc[0]), .op_req(op_req), .op_is_info_row(op_info),
    .target_block(tblk[1:0]), .target_row(trow), .op_inhibit(inh4), .protect_mask(pm4),
    .suspend_and_row_lock(), .read_parameters(), .read_parameters_persistent(),
    .pin_is_reset(), .pin_is_data_lane3(), .dummy_count(),
    .dummy_use_default(), .wrap_enable(), .burst_bytes());
  // counts cycles with the read driver on
  always @(posedge sys_clk) oe_cycles <= oe_cycles + ((miso_oe === 1'b1) ? 1 : 0);
  // ranges wider than half of n blocks protect the whole array
  function automatic logic [15:0] exp_mask(input logic [3:0] c, input int n);
    int k;
    k = 0;
    if (c >= 4'h1 && c <= 4'h4) k = 1 << (c - 1);
    if (c >= 4'hb && c <= 4'he) k = 1 << (14 - c);
    if (c == 4'h0 || c == 4'hf) return 16'h0000;
    if (k == 0 || k > n / 2) return 16'((32'h1 << n) - 1);
    if (c <= 4'h4) return 16'(((32'h1 << k) - 1) << (n - k));
    return 16'((32'h1 << k) - 1);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    samples_checked++;
    if (got !== want) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic chk_rp(input logic [7:0] v);
    chk(16'(rp), 16'(v));
    chk(16'({pin_rst, pin_l3}), 16'({v[7] & ~quad_en & ~four_lane, quad_en | four_lane}));
    chk(16'({dcnt, ddef}), 16'({v[6:3], v[6:3] == 4'h0}));
    chk(16'({wrap, burst}), 16'({v[2], 7'h08 << v[1:0]}));
  endtask
  task automatic settle();
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // a hung run is cut short and counted as a mismatch
  initial begin
    repeat (50000) @(posedge sys_clk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    seed = 42675;
    rst = 1'b1;
    {quad_en, four_lane, pbusy, ebusy, op_req, op_info} = 6'h00;
    pc = 4'h0;
    tblk = 4'h0;
    trow = 2'h0;
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    settle();
    chk(16'(fr), 16'(`FPC_FR_RESET));
    chk(16'(rpp), 16'(`FPC_RP_RESET));
    chk_rp(8'h00);
    op_req = 1'b1;
    for (int c = 0; c < 16; c++) begin
      pc = 4'(c);
      tblk = 4'($random(seed));
      repeat (2) @(negedge sys_clk);
      exp = exp_mask(pc, 16);
      chk(pmask, exp);
      chk(16'(op_inhibit), 16'(exp[tblk]));
      exp = exp_mask(pc, 8);
      chk(16'(pm8), exp);
      chk(16'(inh8), 16'(exp[tblk[2:0]]));
      exp = exp_mask(pc, 4);
      chk(16'(pm4), exp);
      chk(16'(inh4), 16'(exp[tblk[1:0]]));
    end
    pc = 4'h0;
    for (int i = 0; i < 6; i++) begin
      vd = (i == 0) ? 8'hff : 8'($random(seed));
      quad_en = 1'($random(seed));
      four_lane = 1'($random(seed));
      oe_mark = oe_cycles;
      host_u.xfer((i % 2) ? `FPC_OP_SET_RP_V1 : `FPC_OP_SET_RP_V0, vd, 16, rd);
      settle();
      chk_rp(vd);
      chk(16'(rpp), 16'h0000);
      chk(16'(oe_cycles == oe_mark), 16'h0001);
      oe_mark = oe_cycles;
      host_u.xfer(`FPC_OP_RD_RP, 8'h00, 16, rd);
      chk(16'({rd, miso_oe}), 16'({vd, 1'b0}));
      chk(16'(oe_cycles > oe_mark), 16'h0001);
    end
    d = 8'($random(seed));
    host_u.xfer(`FPC_OP_SET_RP_NV, d, 16, rd);
    settle();
    chk(16'(rpp), 16'h0000);
    host_u.set_write_enable();
    host_u.xfer(`FPC_OP_SET_RP_NV, d, 16, rd);
    settle();
    chk(16'({rpp, rp}), 16'({d, vd}));
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    settle();
    chk(16'(rp), 16'(`FPC_RP_RESET));
    for (int k = 0; k < 2; k++) begin
      pbusy = (k == 0);
      ebusy = (k == 1);
      host_u.xfer(`FPC_OP_SUSPEND, 8'h00, 8, rd);
      settle();
      chk(16'(fr), (k == 0) ? 16'h0004 : 16'h0008);
      pbusy = 1'b0;
      ebusy = 1'b0;
      host_u.xfer(`FPC_OP_RESUME, 8'h00, 8, rd);
      settle();
      chk(16'(fr), 16'h0000);
    end
    host_u.set_write_enable();
    host_u.xfer(`FPC_OP_WR_FUNC, 8'h5f, 16, rd);
    settle();
    chk(16'(fr), 16'h0050);
    host_u.set_write_enable();
    host_u.xfer(`FPC_OP_WR_FUNC, 8'h20, 16, rd);
    host_u.xfer(`FPC_OP_WR_FUNC, 8'h80, 16, rd);
    settle();
    chk(16'(fr), 16'h0070);
    host_u.xfer(`FPC_OP_RD_FUNC, 8'h00, 16, rd);
    chk(16'(rd), 16'h0070);
    op_info = 1'b1;
    for (int r = 0; r < 4; r++) begin
      trow = 2'(r);
      repeat (2) @(negedge sys_clk);
      chk(16'(op_inhibit), 16'((4'h7 >> r) & 4'h1));
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
